// File: rtl/uart_status_pkg.sv
package uart_status_pkg;
    // ==========================================================
    // Register map.
    localparam logic [7:0] OFF_RX_DATA = 8'h00;
    localparam logic [7:0] OFF_LINE_STATE = 8'h14;
    localparam logic [7:0] OFF_MODEM_STATE = 8'h18;
    localparam logic [7:0] OFF_SCRATCH = 8'h1C;
    // ==========================================================
    // Line status field positions.
    localparam int LS_DATA_READY = 0;
    localparam int LS_OVERRUN = 1;
    localparam int LS_PARITY = 2;
    localparam int LS_FRAMING = 3;
    localparam int LS_BREAK = 4;
    localparam int LS_HOLD_EMPTY = 5;
    localparam int LS_TX_EMPTY = 6;
    localparam int LS_RX_FIFO_ERR = 7;
    // ==========================================================
    // Modem status field positions.
    localparam int MS_DELTA_CTS = 0;
    localparam int MS_DELTA_DSR = 1;
    localparam int MS_TRAIL_RING = 2;
    localparam int MS_DELTA_DCD = 3;
    localparam int MS_CTS = 4;
    localparam int MS_DSR = 5;
    localparam int MS_RING = 6;
    localparam int MS_DCD = 7;
    // ==========================================================
    // Receive entry layout and sizes.
    localparam int RX_DEPTH = 32;
    localparam int RX_ENTRY_W = 11;
    localparam int ENT_PARITY = 8;
    localparam int ENT_FRAMING = 9;
    localparam int ENT_BREAK = 10;
    localparam int LEVEL_W = 6;
    localparam logic [LEVEL_W-1:0] ERR_STEP = 6'h01;
    localparam logic [LEVEL_W-1:0] ERR_NONE = 6'h00;
    // ==========================================================
    // Transmit threshold levels selected by the two-bit field.
    localparam logic [LEVEL_W-1:0] THR_LVL_EMPTY = 6'h00;
    localparam logic [LEVEL_W-1:0] THR_LVL_TWO = 6'h02;
    localparam logic [LEVEL_W-1:0] THR_LVL_QUARTER = 6'h08;
    localparam logic [LEVEL_W-1:0] THR_LVL_HALF = 6'h10;
    localparam logic [1:0] THR_SEL_EMPTY = 2'h0;
    localparam logic [1:0] THR_SEL_TWO = 2'h1;
    localparam logic [1:0] THR_SEL_QUARTER = 2'h2;
    // ==========================================================
    // Reset values.
    localparam logic TX_EMPTY_RESET = 1'b1;
    localparam logic HOLD_EMPTY_RESET = 1'b1;
    localparam logic MODEM_IDLE = 1'b1;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// File: rtl/uart_line_modem_status.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Receive buffer.
module rx_buffer_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    logic [PTR_W-1:0] next_wr_ptr, next_rd_ptr;
    logic [PTR_W:0] next_count;
    logic do_push, do_pop;

    assign in_ready = (count != CNT_FULL);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_push = in_valid & in_ready;
    assign do_pop = out_valid & out_ready;

    always_comb begin
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + 1'b1;
        end else if (do_pop && !do_push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // rx_buffer_fifo

module uart_line_modem_status
    import uart_status_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic FIFO_EN,
    input wire logic PROG_HOLD_EMPTY,
    input wire logic HOLD_EMPTY_IRQ_EN,
    input wire logic [1:0] FIFO_THRESH,
    input wire logic PARITY_ON,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_PERR,
    input wire logic RX_FERR,
    input wire logic RX_BREAK,
    input wire logic TX_WRITE,
    input wire logic TX_LOAD,
    input wire logic TX_SRC_EMPTY,
    input wire logic TX_SHIFT_EMPTY,
    input wire logic TX_FIFO_FULL,
    input wire logic [5:0] TX_LEVEL,
    input wire logic DCD_N,
    input wire logic RING_IN,
    input wire logic DSR_N,
    input wire logic CTS_N,
    output logic HOLD_EMPTY_IRQ,
    output logic TX_PARITY_EN
);
    // ==========================================================
    // Receive path.
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [RX_ENTRY_W-1:0] entry;
    logic [RX_ENTRY_W-1:0] head;
    logic entry_err;
    logic head_err;
    logic overrun_evt;
    logic setup;
    logic rd_line, rd_modem, rd_data, wr_scratch, mapped;

    function automatic logic [LEVEL_W-1:0] thresh_level(input logic [1:0] sel);
        unique case (sel)
            THR_SEL_EMPTY: thresh_level = THR_LVL_EMPTY;
            THR_SEL_TWO: thresh_level = THR_LVL_TWO;
            THR_SEL_QUARTER: thresh_level = THR_LVL_QUARTER;
            default: thresh_level = THR_LVL_HALF;
        endcase
    endfunction

    assign setup = PSEL & ~PENABLE;
    assign rd_line = setup & ~PWRITE & (PADDR == OFF_LINE_STATE);
    assign rd_modem = setup & ~PWRITE & (PADDR == OFF_MODEM_STATE);
    assign rd_data = setup & ~PWRITE & (PADDR == OFF_RX_DATA);
    assign wr_scratch = setup & PWRITE & (PADDR == OFF_SCRATCH);
    assign mapped = (PADDR == OFF_RX_DATA) | (PADDR == OFF_LINE_STATE)
                  | (PADDR == OFF_MODEM_STATE) | (PADDR == OFF_SCRATCH);

    // Without FIFO mode the buffer behaves as a single holding register.
    assign fifo_in_valid = RX_VALID & (FIFO_EN | ~fifo_out_valid);
    assign overrun_evt = RX_VALID & ~(fifo_in_ready & (FIFO_EN | ~fifo_out_valid));
    assign fifo_pop = rd_data & fifo_out_valid;
    assign entry = {RX_BREAK, RX_FERR, RX_PERR & PARITY_ON, RX_DATA};
    assign entry_err = entry[ENT_PARITY] | entry[ENT_FRAMING] | entry[ENT_BREAK];
    assign head_err = head[ENT_PARITY] | head[ENT_FRAMING] | head[ENT_BREAK];

    rx_buffer_fifo #(
        .WIDTH(RX_ENTRY_W),
        .DEPTH(RX_DEPTH)
    ) u_rx_fifo (
        .clk(CLK_SYS),
        .nrst(NRST),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(entry),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(head)
    );

    // ==========================================================
    // Status state.
    logic [LEVEL_W-1:0] err_cnt;
    logic ovr, perr, ferr, brk;
    logic hold_empty, tx_empty;
    logic [3:0] modem_prev;
    logic [3:0] delta;
    logic [7:0] scratch;
    logic [LEVEL_W-1:0] next_err_cnt;
    logic next_ovr, next_perr, next_ferr, next_brk;
    logic next_hold_empty, next_tx_empty;
    logic [3:0] next_modem_prev;
    logic [3:0] next_delta;
    logic [7:0] next_scratch;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;
    logic [7:0] line_value, modem_value;
    logic thr_mode;
    logic [3:0] modem_now;

    assign thr_mode = PROG_HOLD_EMPTY & FIFO_EN;
    assign modem_now = {DCD_N, RING_IN, DSR_N, CTS_N};

    always_comb begin
        next_err_cnt = err_cnt;
        if (fifo_in_valid && fifo_in_ready && entry_err) begin
            next_err_cnt = next_err_cnt + ERR_STEP;
        end
        if (fifo_pop && head_err) begin
            next_err_cnt = next_err_cnt - ERR_STEP;
        end
        next_ovr = overrun_evt | (ovr & ~rd_line);
        next_perr = (RX_VALID & RX_PERR & PARITY_ON) | (perr & ~rd_line);
        next_ferr = (RX_VALID & RX_FERR) | (ferr & ~rd_line);
        next_brk = (RX_VALID & RX_BREAK) | (brk & ~rd_line);
        next_hold_empty = hold_empty;
        if (TX_WRITE) begin
            next_hold_empty = 1'b0;
        end else if (TX_LOAD && TX_SRC_EMPTY) begin
            next_hold_empty = 1'b1;
        end
        next_tx_empty = TX_SRC_EMPTY & TX_SHIFT_EMPTY;
        if (thr_mode) begin
            next_irq = HOLD_EMPTY_IRQ_EN & (TX_LEVEL <= thresh_level(FIFO_THRESH));
        end else begin
            next_irq = HOLD_EMPTY_IRQ_EN & hold_empty;
        end
        next_modem_prev = modem_now;
        next_delta[MS_DELTA_CTS] = (CTS_N ^ modem_prev[0]) | (delta[0] & ~rd_modem);
        next_delta[MS_DELTA_DSR] = (DSR_N ^ modem_prev[1]) | (delta[1] & ~rd_modem);
        next_delta[MS_TRAIL_RING] = (RING_IN & ~modem_prev[2]) | (delta[2] & ~rd_modem);
        next_delta[MS_DELTA_DCD] = (DCD_N ^ modem_prev[3]) | (delta[3] & ~rd_modem);
        next_scratch = wr_scratch ? PWDATA[7:0] : scratch;
        line_value = '0;
        line_value[LS_RX_FIFO_ERR] = FIFO_EN & (err_cnt != ERR_NONE);
        line_value[LS_TX_EMPTY] = tx_empty;
        line_value[LS_HOLD_EMPTY] = thr_mode ? TX_FIFO_FULL : hold_empty;
        line_value[LS_BREAK] = brk;
        line_value[LS_FRAMING] = ferr;
        line_value[LS_PARITY] = perr;
        line_value[LS_OVERRUN] = ovr;
        line_value[LS_DATA_READY] = fifo_out_valid;
        modem_value = {~modem_prev, delta};
        next_prdata = PRDATA;
        if (setup && !PWRITE) begin
            unique case (PADDR)
                OFF_RX_DATA: next_prdata = {24'h00_0000, head[7:0]};
                OFF_LINE_STATE: next_prdata = {24'h00_0000, line_value};
                OFF_MODEM_STATE: next_prdata = {24'h00_0000, modem_value};
                OFF_SCRATCH: next_prdata = {24'h00_0000, scratch};
                default: next_prdata = RDATA_ZERO;
            endcase
        end
        next_pready = setup;
        next_pslverr = setup & ~mapped;
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            err_cnt <= ERR_NONE;
            ovr <= 1'b0;
            perr <= 1'b0;
            ferr <= 1'b0;
            brk <= 1'b0;
            hold_empty <= HOLD_EMPTY_RESET;
            tx_empty <= TX_EMPTY_RESET;
            modem_prev <= {4{MODEM_IDLE}};
            delta <= '0;
            scratch <= SCRATCH_RESET;
            PRDATA <= RDATA_ZERO;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            HOLD_EMPTY_IRQ <= 1'b0;
            TX_PARITY_EN <= 1'b0;
        end else begin
            err_cnt <= next_err_cnt;
            ovr <= next_ovr;
            perr <= next_perr;
            ferr <= next_ferr;
            brk <= next_brk;
            hold_empty <= next_hold_empty;
            tx_empty <= next_tx_empty;
            modem_prev <= next_modem_prev;
            delta <= next_delta;
            scratch <= next_scratch;
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
            HOLD_EMPTY_IRQ <= next_irq;
            TX_PARITY_EN <= PARITY_ON;
        end
    end

    // ==========================================================
    // Checks.
    a_err_count_up: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        fifo_in_valid && fifo_in_ready && entry_err && !fifo_pop
        |=> err_cnt == $past(err_cnt) + ERR_STEP)
        else $error("error count did not rise");
    a_tx_empty_follow: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        TX_SRC_EMPTY && TX_SHIFT_EMPTY ##1 rd_line |=> PRDATA[LS_TX_EMPTY])
        else $error("transmitter empty not reported");
    a_hold_set_load: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        TX_LOAD && TX_SRC_EMPTY && !TX_WRITE |=> hold_empty)
        else $error("holding empty not set after load");
    a_irq_on_empty: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !thr_mode && HOLD_EMPTY_IRQ_EN && hold_empty |=> HOLD_EMPTY_IRQ)
        else $error("transmit empty interrupt missing");
    a_full_report: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        rd_line && thr_mode |=> PRDATA[LS_HOLD_EMPTY] == $past(TX_FIFO_FULL))
        else $error("full flag not reported in threshold mode");
    a_break_sticky: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        RX_VALID && RX_BREAK ##1 !rd_line |=> brk)
        else $error("break flag lost");
    a_parity_gate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !perr && !(RX_VALID && RX_PERR && PARITY_ON) |=> !perr)
        else $error("parity flag set without cause");
    a_overrun_full: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        RX_VALID && !fifo_in_ready |=> ovr)
        else $error("overrun not flagged");
    a_ready_read: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        rd_line |=> PRDATA[LS_DATA_READY] == $past(fifo_out_valid))
        else $error("data ready mismatch");
    a_ring_trail: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !RING_IN ##1 RING_IN |=> delta[MS_TRAIL_RING])
        else $error("ring trailing edge missed");
    a_modem_clear: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        rd_modem && (modem_now == modem_prev) |=> delta == 4'h0)
        else $error("modem change bits not cleared");
    a_scratch_store: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wr_scratch |=> scratch == $past(PWDATA[7:0]))
        else $error("scratch write lost");
endmodule // uart_line_modem_status

`default_nettype wire

// File: dv/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial and modem peer that delivers characters and modem lines.
module serial_peer (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_perr,
    output logic rx_ferr,
    output logic rx_break,
    output logic dcd_n,
    output logic ring_in,
    output logic dsr_n,
    output logic cts_n
);
    initial begin
        rx_valid = 1'h0;
        rx_data = 8'hC3;
        {rx_perr, rx_ferr, rx_break} = 3'h0;
        {dcd_n, ring_in, dsr_n, cts_n} = 4'hF;
    end
    // One character per pulse; the data lines change once the pulse is over.
    task automatic send_char(input logic [7:0] d, input logic [2:0] err);
        @(posedge clk);
        rx_valid <= 1'h1;
        rx_data <= d;
        {rx_perr, rx_ferr, rx_break} <= err;
        @(posedge clk);
        rx_valid <= 1'h0;
        rx_data <= ~d;
        {rx_perr, rx_ferr, rx_break} <= 3'h0;
    endtask
    task automatic set_lines(input logic [3:0] v);
        @(posedge clk);
        {dcd_n, ring_in, dsr_n, cts_n} <= v;
    endtask
endmodule // serial_peer
`default_nettype wire

// File: dv/uart_line_modem_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_status_tb import uart_status_pkg::*;;
    logic CLK_SYS, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0] PADDR, RX_DATA;
    logic [31:0] PWDATA, PRDATA, rdata;
    logic FIFO_EN, PROG_HOLD_EMPTY, HOLD_EMPTY_IRQ_EN, PARITY_ON;
    logic RX_VALID, RX_PERR, RX_FERR, RX_BREAK;
    logic [1:0] FIFO_THRESH;
    logic TX_WRITE, TX_LOAD, TX_SRC_EMPTY, TX_SHIFT_EMPTY, TX_FIFO_FULL, rerr;
    logic [5:0] TX_LEVEL;
    logic DCD_N, RING_IN, DSR_N, CTS_N, HOLD_EMPTY_IRQ, TX_PARITY_EN;
    int failures = 0;
    int checked = 0;
    uart_line_modem_status uut (
        .CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .FIFO_EN(FIFO_EN), .PROG_HOLD_EMPTY(PROG_HOLD_EMPTY),
        .HOLD_EMPTY_IRQ_EN(HOLD_EMPTY_IRQ_EN),
        .FIFO_THRESH(FIFO_THRESH), .PARITY_ON(PARITY_ON), .RX_VALID(RX_VALID),
        .RX_DATA(RX_DATA), .RX_PERR(RX_PERR), .RX_FERR(RX_FERR), .RX_BREAK(RX_BREAK),
        .TX_WRITE(TX_WRITE), .TX_LOAD(TX_LOAD), .TX_SRC_EMPTY(TX_SRC_EMPTY),
        .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .TX_FIFO_FULL(TX_FIFO_FULL), .TX_LEVEL(TX_LEVEL),
        .DCD_N(DCD_N), .RING_IN(RING_IN), .DSR_N(DSR_N), .CTS_N(CTS_N),
        .HOLD_EMPTY_IRQ(HOLD_EMPTY_IRQ), .TX_PARITY_EN(TX_PARITY_EN)
    );
    serial_peer peer (
        .clk(CLK_SYS), .rx_valid(RX_VALID), .rx_data(RX_DATA), .rx_perr(RX_PERR),
        .rx_ferr(RX_FERR), .rx_break(RX_BREAK), .dcd_n(DCD_N), .ring_in(RING_IN),
        .dsr_n(DSR_N), .cts_n(CTS_N)
    );
    // ==========================================================
    // Clock, watchdog and shared tasks.
    initial begin
        CLK_SYS = 1'h0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        #100_000;
        failures++;
        give_verdict();
    end
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        checked++;
        if ((got & mask) !== (exp & mask)) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h mask %h", $time, got, exp, mask);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'h1;
        PENABLE <= 1'h0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'h1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'h1 && n < 16);
        rdata = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        if (n >= 16) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        apb(1'h0, a, 32'h0000_0000);
        cmp(rdata, exp, mask);
        cmp({31'h0, rerr}, 32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic settle();
        repeat (3) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
    endtask
    task automatic irq_is(input logic e);
        settle();
        cmp({31'h0, HOLD_EMPTY_IRQ}, {31'h0, e}, 32'h0000_0001);
    endtask
    task automatic tx_pulse(input logic ld, input logic src_empty);
        @(posedge CLK_SYS);
        TX_WRITE <= ~ld;
        TX_LOAD <= ld;
        TX_SRC_EMPTY <= src_empty;
        if (ld) TX_SHIFT_EMPTY <= 1'h0;
        @(posedge CLK_SYS);
        TX_WRITE <= 1'h0;
        TX_LOAD <= 1'h0;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        rd(OFF_LINE_STATE, 32'h0000_0060, 32'hFFFF_FFFF);
        rd(OFF_MODEM_STATE, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(OFF_SCRATCH, 32'h0000_0000, 32'hFFFF_FFFF);
        $display("reset values finished");
    endtask
    task automatic t_regs();
        apb(1'h1, OFF_SCRATCH, 32'hFFFF_FFA5);
        rd(OFF_SCRATCH, 32'h0000_00A5, 32'hFFFF_FFFF);
        apb(1'h1, OFF_LINE_STATE, 32'h0000_00FF);
        apb(1'h1, OFF_MODEM_STATE, 32'h0000_00FF);
        rd(OFF_LINE_STATE, 32'h0000_0060, 32'hFFFF_FFFF);
        rd(OFF_MODEM_STATE, 32'h0000_0000, 32'hFFFF_FFFF);
        apb(1'h0, 8'h20, 32'h0000_0000);
        cmp({31'h0, rerr}, 32'h0000_0001, 32'h0000_0001);
        cmp(rdata, 32'h0000_0000, 32'hFFFF_FFFF);
        apb(1'h1, 8'h20, 32'h0000_005A);
        cmp({31'h0, rerr}, 32'h0000_0001, 32'h0000_0001);
        rd(OFF_SCRATCH, 32'h0000_00A5, 32'hFFFF_FFFF);
        apb(1'h1, OFF_SCRATCH, 32'h0000_003C);
        rd(OFF_SCRATCH, 32'h0000_003C, 32'hFFFF_FFFF);
        $display("registers finished");
    endtask
    task automatic t_modem();
        logic [3:0] lines [6] = '{4'h7, 4'h3, 4'h7, 4'h5, 4'h4, 4'hF};
        logic [7:0] expv [6] = '{8'h88, 8'hC0, 8'h84, 8'hA2, 8'hB1, 8'h0B};
        for (int i = 0; i < 6; i++) begin
            peer.set_lines(lines[i]);
            settle();
            rd(OFF_MODEM_STATE, {24'h0, expv[i]}, 32'hFFFF_FFFF);
            rd(OFF_MODEM_STATE, {24'h0, expv[i] & 8'hF0}, 32'hFFFF_FFFF);
        end
        $display("modem status finished");
    endtask
    task automatic t_rx_single();
        @(posedge CLK_SYS);
        FIFO_EN <= 1'h0;
        PARITY_ON <= 1'h1;
        peer.send_char(8'h5A, 3'h0);
        settle();
        rd(OFF_LINE_STATE, 32'h0000_0001, 32'h0000_001F);
        peer.send_char(8'hA7, 3'h0);
        settle();
        rd(OFF_LINE_STATE, 32'h0000_0003, 32'h0000_001F);
        rd(OFF_LINE_STATE, 32'h0000_0001, 32'h0000_001F);
        rd(OFF_RX_DATA, 32'h0000_005A, 32'hFFFF_FFFF);
        rd(OFF_LINE_STATE, 32'h0000_0000, 32'h0000_001F);
        $display("single receive finished");
    endtask
    task automatic t_rx_errors();
        @(posedge CLK_SYS);
        FIFO_EN <= 1'h1;
        PARITY_ON <= 1'h0;
        settle();
        cmp({31'h0, TX_PARITY_EN}, 32'h0000_0000, 32'h0000_0001);
        peer.send_char(8'h11, 3'h4);
        settle();
        rd(OFF_LINE_STATE, 32'h0000_0001, 32'h0000_0085);
        @(posedge CLK_SYS);
        PARITY_ON <= 1'h1;
        peer.send_char(8'h22, 3'h4);
        peer.send_char(8'h33, 3'h2);
        peer.send_char(8'h44, 3'h1);
        settle();
        cmp({31'h0, TX_PARITY_EN}, 32'h0000_0001, 32'h0000_0001);
        rd(OFF_LINE_STATE, 32'h0000_009D, 32'h0000_009F);
        rd(OFF_LINE_STATE, 32'h0000_0081, 32'h0000_009F);
        for (int i = 0; i < 4; i++) begin
            rd(OFF_RX_DATA, {24'h0, 8'h11 * 8'(i + 1)}, 32'hFFFF_FFFF);
        end
        rd(OFF_LINE_STATE, 32'h0000_0000, 32'h0000_009F);
        $display("receive errors finished");
    endtask
    task automatic t_rx_fill();
        for (int i = 0; i < 33; i++) peer.send_char(8'h40 + 8'(i), 3'h0);
        settle();
        rd(OFF_LINE_STATE, 32'h0000_0003, 32'h0000_0003);
        for (int i = 0; i < 32; i++) begin
            rd(OFF_RX_DATA, {24'h0, 8'h40 + 8'(i)}, 32'hFFFF_FFFF);
        end
        rd(OFF_LINE_STATE, 32'h0000_0000, 32'h0000_0003);
        $display("receive fill finished");
    endtask
    task automatic t_tx();
        logic [5:0] thr [4] = '{THR_LVL_EMPTY, THR_LVL_TWO, THR_LVL_QUARTER, THR_LVL_HALF};
        @(posedge CLK_SYS);
        FIFO_EN <= 1'h0;
        HOLD_EMPTY_IRQ_EN <= 1'h1;
        irq_is(1'h1);
        tx_pulse(1'h0, 1'h0);
        irq_is(1'h0);
        rd(OFF_LINE_STATE, 32'h0000_0000, 32'h0000_0060);
        tx_pulse(1'h1, 1'h1);
        irq_is(1'h1);
        rd(OFF_LINE_STATE, 32'h0000_0020, 32'h0000_0060);
        @(posedge CLK_SYS);
        TX_SHIFT_EMPTY <= 1'h1;
        settle();
        rd(OFF_LINE_STATE, 32'h0000_0060, 32'h0000_0060);
        @(posedge CLK_SYS);
        HOLD_EMPTY_IRQ_EN <= 1'h0;
        irq_is(1'h0);
        @(posedge CLK_SYS);
        FIFO_EN <= 1'h1;
        PROG_HOLD_EMPTY <= 1'h1;
        HOLD_EMPTY_IRQ_EN <= 1'h1;
        TX_FIFO_FULL <= 1'h1;
        settle();
        rd(OFF_LINE_STATE, 32'h0000_0020, 32'h0000_0020);
        @(posedge CLK_SYS);
        TX_FIFO_FULL <= 1'h0;
        settle();
        rd(OFF_LINE_STATE, 32'h0000_0000, 32'h0000_0020);
        for (int s = 0; s < 4; s++) begin
            @(posedge CLK_SYS);
            FIFO_THRESH <= 2'(s);
            TX_LEVEL <= thr[s];
            irq_is(1'h1);
            @(posedge CLK_SYS);
            TX_LEVEL <= thr[s] + 6'h01;
            irq_is(1'h0);
        end
        $display("transmit status finished");
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {FIFO_EN, PROG_HOLD_EMPTY, HOLD_EMPTY_IRQ_EN, FIFO_THRESH, PARITY_ON} = '0;
        {TX_WRITE, TX_LOAD, TX_FIFO_FULL, TX_LEVEL} = '0;
        TX_SRC_EMPTY = 1'h1;
        TX_SHIFT_EMPTY = 1'h1;
        repeat (8) @(posedge CLK_SYS);
        NRST <= 1'h1;
        t_reset();
        t_regs();
        t_modem();
        t_rx_single();
        t_rx_errors();
        t_rx_fill();
        t_tx();
        give_verdict();
    end
endmodule // uart_line_modem_status_tb
`default_nettype wire
